// >>> hw/ssrq_params.svh
/*
  Offsets, bit positions, reset values and widths for the status
  reporting and service request block. Assumes inclusion by bare name.
*/
`ifndef SSRQ_PARAMS_SVH
`define SSRQ_PARAMS_SVH

// Questionable condition bit positions
`define SSRQ_Q_VOLT_BIT     0
`define SSRQ_Q_PWR_BIT      3
`define SSRQ_Q_TEMP_BIT     4
`define SSRQ_Q_CAL_BIT      8
`define SSRQ_Q_INST_BIT     13
`define SSRQ_Q_WARN_BIT     14
// Writable mask bits, 0 to 32767
`define SSRQ_QEN_MASK       16'h7fff
// Standard event bit positions
`define SSRQ_E_OPC_BIT      0
`define SSRQ_E_DDE_BIT      3
`define SSRQ_E_EXE_BIT      4
`define SSRQ_E_CME_BIT      5
`define SSRQ_E_PWRON_BIT    7
// Status byte bit positions
`define SSRQ_S_QUES_BIT     3
`define SSRQ_S_EVSUM_BIT    5
`define SSRQ_S_RQS_BIT      6
// Reset values
`define SSRQ_QEN_RST        16'h0000
`define SSRQ_EVMASK_RST     8'h00
`define SSRQ_RQEN_RST       8'h00
`define SSRQ_EVREG_RST      8'h80

`endif

// >>> hw/ssrq_pkg.sv
/*
  Types of the status reporting block: command codes.
  Assumes nothing of its surroundings.
*/
package ssrq_pkg;

  // Commands from the remote command decoder
  typedef enum logic [3:0] {
    SSRQ_RD_QCOND   = 4'h0,
    SSRQ_RD_QEVT    = 4'h1,
    SSRQ_WR_QEN     = 4'h2,
    SSRQ_RD_QEN     = 4'h3,
    SSRQ_CLS        = 4'h4,
    SSRQ_WR_EVMASK  = 4'h5,
    SSRQ_RD_EVMASK  = 4'h6,
    SSRQ_RD_EVREG   = 4'h7,
    SSRQ_WR_RQEN    = 4'h8,
    SSRQ_RD_RQEN    = 4'h9,
    SSRQ_RD_SUMBYTE = 4'ha
  } ssrq_cmd_type;

endpackage : ssrq_pkg

// >>> hw/ssrq_top.sv
/*
  Status reporting and service request logic of a remote interface.
  Assumes a command decoder on the same clock presenting one decoded
  command per cycle, and condition and event sources on the same clock.
*/
// What this block does
// RULE1 - Questionable bit 0 follows supply voltage out of range.
// RULE2 - Questionable bit 3 set while a power measurement error exists.
// RULE3 - Questionable bit 4 set when sensor drifted over 4C since autocal.
// RULE4 - Questionable bit 8 set when a sensor needs calibration or zeroing.
// RULE5 - Questionable condition read returns 16 bits, 0 to 32767.
// RULE6 - Bit 13 instrument summary, bit 14 command warning, others zero.
// RULE7 - Questionable enable mask writable and readable, 0 to 32767.
// RULE8 - Enabled questionable bit going true raises a service request.
// RULE9 - A clear mask bit never raises a request for its condition.
// RULE10 - Status byte summary bits are OR of enabled subordinate bits.
// RULE11 - Clear-status resets status registers, error queue, measurement.
// RULE12 - Standard event enable mask writable and readable, 0 to 255.
// RULE13 - Standard events request service only if request enable bit 5.
// RULE14 - Event bits latch high and the register clears after reading.
// RULE15 - Standard event bits: 0 done, 3 device, 4 exec, 5 cmd, 7 power.
`timescale 1ns/1ns
`include "ssrq_params.svh"

module ssrq_top (
  // Clock and reset
  input  wire logic        CORE_CLK_IN,
  input  wire logic        SRST_IN,
  // Command port
  input  wire logic        CMD_VALID_IN,
  input  wire logic [3:0]  CMD_CODE_IN,
  input  wire logic [15:0] CMD_DATA_IN,
  output logic             RD_VALID_OUT,
  output logic      [15:0] RD_DATA_OUT,
  // Questionable condition sources (levels)
  input  wire logic        SUPPLY_FAULT_IN,
  input  wire logic        POWER_ERROR_IN,
  input  wire logic        TEMP_DRIFT_IN,
  input  wire logic        CAL_NEEDED_IN,
  input  wire logic        INST_SUMMARY_IN,
  input  wire logic        CMD_WARNING_IN,
  // Standard event sources (pulses)
  input  wire logic        OP_COMPLETE_IN,
  input  wire logic        DEV_ERROR_IN,
  input  wire logic        EXEC_ERROR_IN,
  input  wire logic        CMD_ERROR_IN,
  // Service request and clear-status side effects
  output logic             SRQ_OUT,
  output logic             ERRQ_CLEAR_OUT,
  output logic             MEAS_CLEAR_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] qen;
    logic [15:0] qevt;
    logic [7:0]  std_event_enable_mask;
    logic [7:0]  std_event_register;
    logic [7:0]  service_request_enable;
    logic        rd_valid;
    logic [15:0] rd_data;
    logic        errq_clr;
    logic        meas_clr;
    logic        srq;
  } ssrq_state_type;

  ssrq_state_type q;
  ssrq_state_type d;

  logic [15:0] qcond;
  logic [7:0]  ev_set;
  logic        ques_sum;
  logic        event_summary_flag;
  logic [7:0]  service_summary_byte;
  logic        cmd_hit;
  logic        is_cls;

  // ----------------------------------------------------------------
  // Condition and summaries
  // ----------------------------------------------------------------
  // Live questionable condition; unassigned bits stay zero
  always_comb begin
    qcond                        = 16'h0000;                  // RULE6
    qcond[`SSRQ_Q_VOLT_BIT]      = SUPPLY_FAULT_IN;           // RULE1
    qcond[`SSRQ_Q_PWR_BIT]       = POWER_ERROR_IN;            // RULE2
    qcond[`SSRQ_Q_TEMP_BIT]      = TEMP_DRIFT_IN;             // RULE3
    qcond[`SSRQ_Q_CAL_BIT]       = CAL_NEEDED_IN;             // RULE4
    qcond[`SSRQ_Q_INST_BIT]      = INST_SUMMARY_IN;           // RULE6
    qcond[`SSRQ_Q_WARN_BIT]      = CMD_WARNING_IN;            // RULE6
  end

  // Standard event set terms
  always_comb begin
    ev_set                       = 8'h00;
    ev_set[`SSRQ_E_OPC_BIT]      = OP_COMPLETE_IN;            // RULE15
    ev_set[`SSRQ_E_DDE_BIT]      = DEV_ERROR_IN;              // RULE15
    ev_set[`SSRQ_E_EXE_BIT]      = EXEC_ERROR_IN;             // RULE15
    ev_set[`SSRQ_E_CME_BIT]      = CMD_ERROR_IN;              // RULE15
  end

  // Summary bits of the status byte
  assign ques_sum           = |(q.qevt & q.qen);                 // RULE10
  assign event_summary_flag = |(q.std_event_register             // RULE10
                                & q.std_event_enable_mask);

  always_comb begin
    service_summary_byte                     = 8'h00;
    service_summary_byte[`SSRQ_S_QUES_BIT]   = ques_sum;
    service_summary_byte[`SSRQ_S_EVSUM_BIT]  = event_summary_flag;
    service_summary_byte[`SSRQ_S_RQS_BIT]    = q.srq;
  end

  assign cmd_hit = CMD_VALID_IN;
  assign is_cls  = cmd_hit && (CMD_CODE_IN == ssrq_pkg::SSRQ_CLS);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.rd_valid = 1'b0;
    d.errq_clr = 1'b0;
    d.meas_clr = 1'b0;
    // Command decode
    if (cmd_hit) begin
      case (CMD_CODE_IN)
        ssrq_pkg::SSRQ_RD_QCOND: begin
          d.rd_valid = 1'b1;
          d.rd_data  = qcond & `SSRQ_QEN_MASK;                // RULE5
        end
        ssrq_pkg::SSRQ_RD_QEVT: begin
          d.rd_valid = 1'b1;
          d.rd_data  = q.qevt;
          d.qevt     = 16'h0000;                              // RULE14
        end
        ssrq_pkg::SSRQ_WR_QEN: begin
          d.qen = CMD_DATA_IN & `SSRQ_QEN_MASK;               // RULE7
        end
        ssrq_pkg::SSRQ_RD_QEN: begin
          d.rd_valid = 1'b1;
          d.rd_data  = q.qen;                                 // RULE7
        end
        ssrq_pkg::SSRQ_CLS: begin
          d.qevt               = 16'h0000;                    // RULE11
          d.std_event_register = 8'h00;                       // RULE11
          d.errq_clr           = 1'b1;                        // RULE11
          d.meas_clr           = 1'b1;                        // RULE11
        end
        ssrq_pkg::SSRQ_WR_EVMASK: begin
          d.std_event_enable_mask = CMD_DATA_IN[7:0];         // RULE12
        end
        ssrq_pkg::SSRQ_RD_EVMASK: begin
          d.rd_valid = 1'b1;
          d.rd_data  = {8'h00, q.std_event_enable_mask};      // RULE12
        end
        ssrq_pkg::SSRQ_RD_EVREG: begin
          d.rd_valid           = 1'b1;
          d.rd_data            = {8'h00, q.std_event_register};
          d.std_event_register = 8'h00;                       // RULE14
        end
        ssrq_pkg::SSRQ_WR_RQEN: begin
          d.service_request_enable = CMD_DATA_IN[7:0];        // RULE13
        end
        ssrq_pkg::SSRQ_RD_RQEN: begin
          d.rd_valid = 1'b1;
          d.rd_data  = {8'h00, q.service_request_enable};
        end
        ssrq_pkg::SSRQ_RD_SUMBYTE: begin
          d.rd_valid = 1'b1;
          d.rd_data  = {8'h00, service_summary_byte};
        end
        default: begin
          d.rd_valid = 1'b0;
        end
      endcase
    end
    // Latching of new events; a set beats a same-cycle clear
    d.qevt               = d.qevt | qcond;                    // RULE14
    d.std_event_register = d.std_event_register | ev_set;     // RULE14
    // Service request: questionable summary, or gated event summary
    d.srq = ques_sum                                          // RULE8 RULE9
          | (event_summary_flag                               // RULE13
             & q.service_request_enable[`SSRQ_S_EVSUM_BIT]);
  end

  // Register the state; power-on flag set out of reset
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      q.qen                <= `SSRQ_QEN_RST;
      q.qevt               <= 16'h0000;
      q.std_event_enable_mask  <= `SSRQ_EVMASK_RST;
      q.std_event_register     <= `SSRQ_EVREG_RST;            // RULE15
      q.service_request_enable <= `SSRQ_RQEN_RST;
      q.rd_valid           <= 1'b0;
      q.rd_data            <= 16'h0000;
      q.errq_clr           <= 1'b0;
      q.meas_clr           <= 1'b0;
      q.srq                <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign RD_VALID_OUT   = q.rd_valid;
  assign RD_DATA_OUT    = q.rd_data;
  assign SRQ_OUT        = q.srq;
  assign ERRQ_CLEAR_OUT = q.errq_clr;
  assign MEAS_CLEAR_OUT = q.meas_clr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);

  // Command match helper, declared ahead of its first use
  function automatic logic is_cmd(input ssrq_pkg::ssrq_cmd_type c);
    is_cmd = CMD_VALID_IN && (CMD_CODE_IN == c);
  endfunction : is_cmd

  wire rd_qcond = is_cmd(ssrq_pkg::SSRQ_RD_QCOND);

  supply_bit_a: assert property (rd_qcond |=> RD_VALID_OUT && // RULE1
    RD_DATA_OUT[0] == $past(SUPPLY_FAULT_IN))
    else $error("supply bit wrong on condition read");

  power_bit_a: assert property (rd_qcond |=> // RULE2
    RD_DATA_OUT[3] == $past(POWER_ERROR_IN))
    else $error("power error bit wrong on condition read");

  temp_cal_a: assert property (rd_qcond |=> // RULE3 RULE4
    RD_DATA_OUT[4] == $past(TEMP_DRIFT_IN) &&
    RD_DATA_OUT[8] == $past(CAL_NEEDED_IN))
    else $error("drift or calibration bit wrong");

  cond_range_a: assert property (rd_qcond |=> // RULE5 RULE6
    (RD_DATA_OUT & 16'h9ee6) == 16'h0000 &&
    RD_DATA_OUT[14] == $past(CMD_WARNING_IN))
    else $error("unassigned condition bits not zero");

  qen_write_a: assert property (is_cmd(ssrq_pkg::SSRQ_WR_QEN) // RULE7
    |=> q.qen == ($past(CMD_DATA_IN) & 16'h7fff))
    else $error("questionable mask not written");

  srq_raise_a: assert property (|(q.qevt & q.qen) |=> SRQ_OUT) // RULE8
    else $error("enabled questionable event gave no request");

  srq_cause_a: assert property (SRQ_OUT |-> // RULE9 RULE13
    $past(|(q.qevt & q.qen)) ||
    $past(|(q.std_event_register & q.std_event_enable_mask) &&
    q.service_request_enable[5]))
    else $error("request without enabled cause");

  evsum_gate_a: assert property ( // RULE13
    (q.qevt & q.qen) == 16'h0000 && !q.service_request_enable[5]
    |=> !SRQ_OUT)
    else $error("event summary requested service while disabled");

  cls_clear_a: assert property (is_cls && ev_set == 8'h00 && // RULE11
    qcond == 16'h0000 |=> q.std_event_register == 8'h00 &&
    q.qevt == 16'h0000 && ERRQ_CLEAR_OUT && MEAS_CLEAR_OUT)
    else $error("clear status incomplete");

  evreg_read_a: assert property (is_cmd(ssrq_pkg::SSRQ_RD_EVREG) // RULE14
    |=> RD_DATA_OUT[7:0] == $past(q.std_event_register) &&
    q.std_event_register == $past(ev_set))
    else $error("event register read not clear on read");

  evmask_write_a: assert property ( // RULE12
    is_cmd(ssrq_pkg::SSRQ_WR_EVMASK)
    |=> q.std_event_enable_mask == $past(CMD_DATA_IN[7:0]))
    else $error("event enable mask not written");

endmodule : ssrq_top

// >>> verif/ssrq_host.sv
/*
  Remote host model: issues decoded commands and collects read answers.
  Assumes the block takes a command on a rising edge and answers one
  cycle later.
*/
`timescale 1ns/1ns

module ssrq_host (
  // Clock
  input  wire logic        clk_in,
  // Answer from the block
  input  wire logic        rd_valid_in,
  input  wire logic [15:0] rd_data_in,
  // Command to the block
  output logic             cmd_valid_out,
  output logic      [3:0]  cmd_code_out,
  output logic      [15:0] cmd_data_out
);
  // Idle lines at time zero
  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out  = 4'h0;
    cmd_data_out  = 16'h0000;
  end

  // One command, held across exactly one rising edge
  task automatic send(input logic [3:0] code, input logic [15:0] data);
    @(negedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_code_out  <= code;
    cmd_data_out  <= data;
    @(negedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_code_out  <= ~code;  // Released lines lose the old value
    cmd_data_out  <= ~data;
  endtask : send

  // Query: answer stands in the cycle after the take edge
  task automatic query(input logic [3:0] code, output logic [15:0] val,
                       output logic ok);
    send(code, 16'h0000);
    ok  = rd_valid_in;
    val = rd_data_in;
  endtask : query
endmodule : ssrq_host

// >>> verif/status_reporting_srq_logic_tb_top.sv
/*
  Self-checking bench of the status reporting block.
  Assumes the host model and one 100 MHz clock.
*/
`timescale 1ns/1ns

module status_reporting_srq_logic_tb_top;
  logic        clk, srst, vld, rv, srq, errq, meas, ok;
  logic [3:0]  code, ev;
  logic [5:0]  cond, c;
  logic [15:0] data, rdat, v, d;
  int          n_fail, checked, seed, i;

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ssrq_host h (.clk_in(clk), .rd_valid_in(rv), .rd_data_in(rdat),
    .cmd_valid_out(vld), .cmd_code_out(code), .cmd_data_out(data));

  ssrq_top dut (.CORE_CLK_IN(clk), .SRST_IN(srst), .CMD_VALID_IN(vld),
    .CMD_CODE_IN(code), .CMD_DATA_IN(data), .RD_VALID_OUT(rv),
    .RD_DATA_OUT(rdat), .SUPPLY_FAULT_IN(cond[0]),
    .POWER_ERROR_IN(cond[1]), .TEMP_DRIFT_IN(cond[2]),
    .CAL_NEEDED_IN(cond[3]), .INST_SUMMARY_IN(cond[4]),
    .CMD_WARNING_IN(cond[5]), .OP_COMPLETE_IN(ev[0]),
    .DEV_ERROR_IN(ev[1]), .EXEC_ERROR_IN(ev[2]), .CMD_ERROR_IN(ev[3]),
    .SRQ_OUT(srq), .ERRQ_CLEAR_OUT(errq), .MEAS_CLEAR_OUT(meas));

  // Expected condition word from the source levels
  function automatic logic [15:0] qexp(input logic [5:0] s);
    qexp = {1'b0, s[5], s[4], 4'h0, s[3], 3'h0, s[2], s[1], 2'h0, s[0]};
  endfunction : qexp

  // Expected standard event byte from the pulsed sources
  function automatic logic [15:0] eexp(input logic [3:0] s);
    eexp = {8'h00, 2'h0, s[3], s[2], s[1], 2'h0, s[0]};
  endfunction : eexp

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [3:0] cd, output logic [15:0] val);
    h.query(cd, val, ok);
    chk("rd_valid", 16'h0001, {15'h0, ok});
  endtask : rd

  task automatic results;
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // Watchdog
  initial begin
    #200000;
    n_fail++;
    results();
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    cond = 6'h00;
    ev = 4'h0;
    seed = 56199;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    rd(ssrq_pkg::SSRQ_RD_QEN, v);
    chk("qen_rst", 16'h0000, v);
    rd(ssrq_pkg::SSRQ_RD_EVMASK, v);
    chk("evmask_rst", 16'h0000, v);
    rd(ssrq_pkg::SSRQ_RD_EVREG, v);
    chk("evreg_pwron", 16'h0080, v);
    rd(ssrq_pkg::SSRQ_RD_EVREG, v);
    chk("evreg_clr", 16'h0000, v);
    // Unknown code: no answer and no register change
    h.send(4'hb, 16'hffff);
    chk("unknown_code", 16'h0000, {15'h0, rv});
    rd(ssrq_pkg::SSRQ_RD_QEN, v);
    chk("unknown_qen", 16'h0000, v);
    // Condition word under random levels, all-ones first
    for (i = 0; i < 20; i++) begin
      c = (i == 0) ? 6'h3f : 6'($random(seed));
      cond <= c;
      rd(ssrq_pkg::SSRQ_RD_QCOND, v);
      chk("qcond", qexp(c), v);
    end
    cond <= 6'h00;
    h.send(ssrq_pkg::SSRQ_CLS, 16'h0000);
    // Mask write and read back, full-scale first
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 16'hffff : 16'($random(seed));
      h.send(ssrq_pkg::SSRQ_WR_QEN, d);
      rd(ssrq_pkg::SSRQ_RD_QEN, v);
      chk("qen", d & 16'h7fff, v);
      h.send(ssrq_pkg::SSRQ_WR_EVMASK, d);
      rd(ssrq_pkg::SSRQ_RD_EVMASK, v);
      chk("evmask", d & 16'h00ff, v);
      h.send(ssrq_pkg::SSRQ_WR_RQEN, d);
      rd(ssrq_pkg::SSRQ_RD_RQEN, v);
      chk("rqen", d & 16'h00ff, v);
    end
    // Each questionable source, masked then enabled
    for (i = 0; i < 6; i++) begin
      h.send(ssrq_pkg::SSRQ_WR_QEN, 16'h0000);
      cond <= 6'h01 << i;
      repeat (3) @(negedge clk);
      chk("srq_masked", 16'h0000, {15'h0, srq});
      h.send(ssrq_pkg::SSRQ_WR_QEN, qexp(6'h01 << i));
      @(negedge clk);
      chk("srq_ques", 16'h0001, {15'h0, srq});
      rd(ssrq_pkg::SSRQ_RD_SUMBYTE, v);
      chk("sumb_ques", 16'h0048, v & 16'h0048);
      cond <= 6'h00;
      rd(ssrq_pkg::SSRQ_RD_QEVT, v);
      chk("qevent", qexp(6'h01 << i), v);
      @(negedge clk);
      chk("srq_drop", 16'h0000, {15'h0, srq});
    end
    h.send(ssrq_pkg::SSRQ_WR_QEN, 16'h0000);
    h.send(ssrq_pkg::SSRQ_WR_EVMASK, 16'h00ff);
    // Each standard event, gated by the summary enable
    for (i = 0; i < 4; i++) begin
      h.send(ssrq_pkg::SSRQ_WR_RQEN, 16'h00df);
      ev <= 4'h1 << i;
      @(negedge clk);
      ev <= 4'h0;
      repeat (2) @(negedge clk);
      chk("srq_gated", 16'h0000, {15'h0, srq});
      h.send(ssrq_pkg::SSRQ_WR_RQEN, 16'h0020);
      @(negedge clk);
      chk("srq_event", 16'h0001, {15'h0, srq});
      rd(ssrq_pkg::SSRQ_RD_SUMBYTE, v);
      chk("sumb_evsum", 16'h0060, v & 16'h0060);
      rd(ssrq_pkg::SSRQ_RD_EVREG, v);
      chk("evreg", eexp(4'h1 << i), v);
    end
    // Clear-status with both event registers loaded
    h.send(ssrq_pkg::SSRQ_WR_QEN, 16'h0001);
    cond <= 6'h01;
    ev <= 4'h8;
    @(negedge clk);
    cond <= 6'h00;
    ev <= 4'h0;
    h.send(ssrq_pkg::SSRQ_CLS, 16'h0000);
    chk("clears", 16'h0003, {14'h0, errq, meas});
    @(negedge clk);
    chk("srq_cls", 16'h0000, {13'h0, srq, errq, meas});
    rd(ssrq_pkg::SSRQ_RD_EVREG, v);
    chk("evreg_cls", 16'h0000, v);
    rd(ssrq_pkg::SSRQ_RD_QEVT, v);
    chk("qevt_cls", 16'h0000, v);
    // Reset in mid-run brings back the power-on state
    h.send(ssrq_pkg::SSRQ_WR_QEN, 16'h0001);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    rd(ssrq_pkg::SSRQ_RD_EVREG, v);
    chk("evreg_rst2", 16'h0080, v);
    rd(ssrq_pkg::SSRQ_RD_QEN, v);
    chk("qen_rst2", 16'h0000, v);
    results();
  end
endmodule : status_reporting_srq_logic_tb_top
